// ==== cpu_status_flag_unit_tb_top.sv ====
`timescale 1ns/1ps
module cpu_status_flag_unit_tb_top;
    logic hclk, hresetn, hsel, hwrite, wdt_timeout, hreadyout, hresp;
    logic dummy_cycle, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, sector;
    logic [2:0] hsize;
    logic [15:0] tbl_word;
    logic [15:0] lfsr_q = 16'hD970;
    logic [12:0] tbl_addr, pc;
    logic [7:0] sector_offset;
    logic [7:0] ind[3] = '{csfu_pkg::IDX_IND0, csfu_pkg::IDX_IND1,
        csfu_pkg::IDX_IND2};
    wire hready = hreadyout;
    int error_cnt = 0;
    int tests_run = 0;
    int acc, fl, thr, res, a, b, f, tw, op, p, q;

    csfu_core #(.PC_W(13), .SECT_W(2)) u_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .wdt_timeout(wdt_timeout), .tbl_addr(tbl_addr), .tbl_word(tbl_word),
        .pc(pc), .dummy_cycle(dummy_cycle), .sector(sector),
        .sector_offset(sector_offset), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[14:0],
            lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q[7:0];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx,
        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        hwrite <= w;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50) begin
            error_cnt++;
            final_report;
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        chk(d, exp);
    endtask

    // ----------------------------------------
    // Reference model, one command
    // ----------------------------------------
    task automatic model(input int op, input int b, input int tw);
        int s, c7, cin, z;
        cin = op inside {2, 5, 6} ? fl & 1 : op inside {3, 4};
        if (op inside {[3:6]}) b = b ^ 255;
        s = acc + b + cin;
        c7 = ((acc & 127) + (b & 127) + cin) >> 7;
        z = (s & 255) == 0;
        case (op)
            1, 2, 3, 4, 5, 6: begin
                fl = fl & 'h70 | s >> 8 | z << 2;
                fl = fl | (c7 ^ (s >> 8)) << 3;
                fl = fl | (((acc & 15) + (b & 15) + cin) >> 4) << 1;
                fl = fl | (((fl >> 3) ^ (s >> 7)) & 1) << 7;
                if (op inside {3, 4}) begin
                    fl = fl & 'hBF | z << 6;
                end
                if (op inside {5, 6}) begin
                    fl = fl & ('hBF | z << 6);
                end
                if (op inside {4, 6}) begin
                    res = s & 255;
                end else begin
                    acc = s & 255;
                end
            end
            7, 8, 9: begin
                acc = op == 7 ? acc & b : op == 8 ? acc | b : acc ^ b;
                fl = fl & 'hFB | (acc == 0) << 2;
            end
            10: begin
                s = acc << 1 | fl & 1;
                fl = fl & 'hFE | acc >> 7;
                acc = s & 255;
            end
            11: begin
                s = acc >> 1 | (fl & 1) << 7;
                fl = fl & 'hFE | acc & 1;
                acc = s;
            end
            12: fl = fl & 'hCF;
            13: fl = fl & 'hCF | 'h10;
            14: begin
                thr = tw >> 8;
                res = tw & 255;
            end
            15: acc = b;
            default: ;
        endcase
    endtask

    task automatic final_report;
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 8000);
        error_cnt++;
        final_report;
    end

    initial begin
        {hresetn, hsel, hwrite, wdt_timeout, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        tbl_word = 16'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        fl = 0;
        thr = 0;
        rd_chk(csfu_pkg::IDX_FLAGS, 0);
        for (int i = 0; i < 48; i++) begin
            a = rnd();
            b = rnd();
            f = rnd();
            tw = rnd() << 8 | rnd();
            op = i % 16;
            wr(csfu_pkg::IDX_ACC, a);
            wr(csfu_pkg::IDX_OPND, b);
            rd_chk(csfu_pkg::IDX_FLAGS, fl);
            wr(csfu_pkg::IDX_FLAGS, f);
            tbl_word <= tw[15:0];
            acc = a;
            fl = f & 'hCF | fl & 'h30;
            rd_chk(csfu_pkg::IDX_FLAGS, fl);
            wr(csfu_pkg::IDX_CMD, op);
            model(op, b, tw);
            rd_chk(csfu_pkg::IDX_ACC, acc);
            rd_chk(csfu_pkg::IDX_FLAGS, fl);
            rd_chk(csfu_pkg::IDX_THR, thr);
            if (op inside {4, 6, 14}) begin
                rd_chk(csfu_pkg::IDX_RESULT, res);
            end
            if (op == 14) begin
                rd_chk(csfu_pkg::IDX_TBLDATA, res);
            end
        end
        wr(csfu_pkg::IDX_IRQSTAT, 7);
        wr(csfu_pkg::IDX_IRQMASK, 7);
        p = rnd();
        q = rnd();
        wr(csfu_pkg::IDX_TPL, p);
        wr(csfu_pkg::IDX_TPH, q);
        wr(csfu_pkg::IDX_EXTADDR, 'h1F0);
        wr(csfu_pkg::IDX_PCLB, p);
        #1;
        chk({pc[7:0], dummy_cycle, irq}, {p[7:0], 2'h3});
        chk({sector, sector_offset}, 32'h1F0);
        chk(tbl_addr, {q[4:0], p[7:0]});
        @(posedge hclk);
        rd_chk(csfu_pkg::IDX_IRQSTAT, 2);
        rd_chk(csfu_pkg::IDX_PCFULL, p);
        rd_chk(csfu_pkg::IDX_SECTOR, 1);
        rd_chk(csfu_pkg::IDX_OFFSET, 8'hF0);
        wr(csfu_pkg::IDX_IRQMASK, 0);
        #1 chk(irq, 0);
        @(posedge hclk);
        wr(csfu_pkg::IDX_IRQSTAT, 2);
        rd_chk(csfu_pkg::IDX_IRQSTAT, 0);
        foreach (ind[k]) begin
            wr(ind[k], 'hFF);
            rd_chk(ind[k], 0);
        end
        for (int k = 13; k >= 12; k--) begin
            wdt_timeout <= 1'b1;
            repeat (8) @(posedge hclk);
            wdt_timeout <= 1'b0;
            fl = fl | 'h20;
            rd_chk(csfu_pkg::IDX_FLAGS, fl);
            rd_chk(csfu_pkg::IDX_IRQSTAT, 1);
            wr(csfu_pkg::IDX_IRQSTAT, 1);
            wr(csfu_pkg::IDX_CMD, k);
            model(k, 0, 0);
            rd_chk(csfu_pkg::IDX_FLAGS, fl);
        end
        final_report;
    end
endmodule // cpu_status_flag_unit_tb_top

// ==== csfu_alu.sv ====
`timescale 1ns/1ps
module csfu_alu (
    csfu_alu_if.alu bus
);
    logic [4:0] lo;
    logic [8:0] full;
    logic [7:0] low7;
    logic c7;
    logic [7:0] bb;
    logic ci;
    always_comb begin
        bb = bus.b;
        ci = 1'b0;
        lo = 5'h00;
        full = 9'h000;
        low7 = 8'h00;
        bus.result = 8'h00;
        bus.c = bus.cin;
        bus.ac = 1'b0;
        bus.ov = 1'b0;
        bus.is_arith = 1'b0;
        c7 = 1'b0;
        case (csfu_pkg::csfu_op_e'(bus.op))
            csfu_pkg::CSFU_OP_ADD, csfu_pkg::CSFU_OP_ADC,
            csfu_pkg::CSFU_OP_SUB, csfu_pkg::CSFU_OP_SUBTRACT_TO_MEMORY_INSTRUCTION,
            csfu_pkg::CSFU_OP_SBC, csfu_pkg::CSFU_OP_SBCM: begin
                // Subtract is add of inverted operand; carry means no borrow
                if (bus.op == csfu_pkg::CSFU_OP_ADC) begin
                    ci = bus.cin;
                end else if (bus.op == csfu_pkg::CSFU_OP_SUB ||
                        bus.op == csfu_pkg::CSFU_OP_SUBTRACT_TO_MEMORY_INSTRUCTION) begin
                    bb = ~bus.b;
                    ci = 1'b1;
                end else if (bus.op != csfu_pkg::CSFU_OP_ADD) begin
                    bb = ~bus.b;
                    ci = bus.cin;
                end
                full = {1'b0, bus.a} + {1'b0, bb} + {8'h00, ci};
                lo = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
                low7 = {1'b0, bus.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
                c7 = low7[7];
                bus.result = full[7:0];
                bus.c = full[8];
                bus.ac = lo[4];
                bus.ov = c7 ^ full[8];
                bus.is_arith = 1'b1;
            end
            csfu_pkg::CSFU_OP_AND: bus.result = bus.a & bus.b;
            csfu_pkg::CSFU_OP_OR: bus.result = bus.a | bus.b;
            csfu_pkg::CSFU_OP_XOR: bus.result = bus.a ^ bus.b;
            csfu_pkg::CSFU_OP_RLC: begin
                bus.result = {bus.a[6:0], bus.cin};
                bus.c = bus.a[7];
            end
            csfu_pkg::CSFU_OP_RRC: begin
                bus.result = {bus.cin, bus.a[7:1]};
                bus.c = bus.a[0];
            end
            default: bus.result = bus.b;
        endcase
        bus.z = (bus.result == 8'h00);
        bus.sc = bus.ov ^ bus.result[7];
    end
endmodule // csfu_alu

// ==== csfu_alu_if.sv ====
`timescale 1ns/1ps
interface csfu_alu_if;
    logic [3:0] op;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic [7:0] result;
    logic c;
    logic ac;
    logic z;
    logic ov;
    logic sc;
    logic is_arith;
    modport core (output op, a, b, cin,
        input result, c, ac, z, ov, sc, is_arith);
    modport alu (input op, a, b, cin,
        output result, c, ac, z, ov, sc, is_arith);
endinterface

// ==== csfu_core.sv ====
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module csfu_core #(
    parameter int PC_W = 13,
    parameter int SECT_W = 2
) (
    // Bus clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Watchdog event pin
    input wire logic wdt_timeout,
    // Program memory table port
    output logic [PC_W-1:0] tbl_addr,
    input wire logic [15:0] tbl_word,
    // Program counter
    output logic [PC_W-1:0] pc,
    output logic dummy_cycle,
    // Extended data address
    output logic [SECT_W-1:0] sector,
    output logic [7:0] sector_offset,
    // Interrupt
    output logic irq
);
    // Pointer split and page jump need a high byte above bit 7
    if (PC_W < 9 || PC_W > 16 || SECT_W < 1 || SECT_W > 8) begin : g_bad_width
        $error("csfu_core: unsupported width");
    end

    csfu_alu_if alu_bus ();
    csfu_alu u_alu (.bus(alu_bus));

    function automatic logic is_idx(input logic [31:0] a,
            input logic [7:0] idx);
        is_idx = (a[31:10] == 22'h000000) && (a[9:2] == idx)
            && (a[1:0] == 2'b00);
    endfunction

    // --------------------------------------------------------
    // Bus address phase
    // --------------------------------------------------------
    logic wr_pend;
    logic rd_pend;
    logic [31:0] ap_addr;
    logic wr_go;
    logic [7:0] wd;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_go = wr_pend;
    assign wd = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ap_addr <= 32'h00000000;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            rd_pend <= hsel && htrans[1] && !hwrite;
            ap_addr <= haddr;
        end
    end

    // --------------------------------------------------------
    // Data path registers
    // --------------------------------------------------------
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [7:0] result;
    logic [7:0] flags;
    logic [7:0] tpl;
    logic [7:0] tph;
    logic [7:0] thr;
    logic [7:0] tbl_low;
    logic [15:0] ext_addr;
    localparam int IRQ_W_L = csfu_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_stat;
    logic [IRQ_W_L-1:0] irq_mask;
    logic cmd_go;
    csfu_pkg::csfu_op_e cmd_op;
    logic wdt_s1;
    logic wdt_s2;
    logic wdt_s3;
    logic wdt_lvl;
    logic wdt_ev;

    assign cmd_go = wr_go && is_idx(ap_addr, csfu_pkg::IDX_CMD);
    assign cmd_op = csfu_pkg::csfu_op_e'(hwdata[3:0]);

    assign alu_bus.op = hwdata[3:0];
    assign alu_bus.a = acc;
    assign alu_bus.b = opnd;
    assign alu_bus.cin = flags[csfu_pkg::FLG_C];

    // --------------------------------------------------------
    // Watchdog pin
    // --------------------------------------------------------
    // Pin synchroniser; first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_s1 <= 1'b0;
            wdt_s2 <= 1'b0;
            wdt_s3 <= 1'b0;
        end else begin
            wdt_s1 <= wdt_timeout;
            wdt_s2 <= wdt_s1;
            wdt_s3 <= wdt_s2;
        end
    end
    // Level moves only once the last two stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_lvl <= 1'b0;
        end else if (wdt_s2 == wdt_s3) begin
            wdt_lvl <= wdt_s3;
        end
    end
    assign wdt_ev = wdt_s2 && wdt_s3 && !wdt_lvl;

    // --------------------------------------------------------
    // Accumulator and result
    // --------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc <= 8'h00;
            opnd <= 8'h00;
            result <= 8'h00;
        end else begin
            if (cmd_go && alu_bus.op != csfu_pkg::CSFU_OP_NOP &&
                    cmd_op != csfu_pkg::CSFU_OP_CLRWDT &&
                    cmd_op != csfu_pkg::CSFU_OP_HALT &&
                    cmd_op != csfu_pkg::CSFU_OP_TABRD) begin
                result <= alu_bus.result;
                // Memory-destination forms keep acc untouched
                if (cmd_op != csfu_pkg::CSFU_OP_SUBTRACT_TO_MEMORY_INSTRUCTION &&
                        cmd_op != csfu_pkg::CSFU_OP_SBCM) begin
                    acc <= alu_bus.result;
                end
            end else if (cmd_go && cmd_op == csfu_pkg::CSFU_OP_TABRD) begin
                result <= tbl_word[7:0];
            end else if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_ACC)) begin
                acc <= wd;
            end
            if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_OPND)) begin
                opnd <= wd;
            end
        end
    end

    // --------------------------------------------------------
    // Flags
    // --------------------------------------------------------
    // Interrupt entry and calls do not touch this register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= csfu_pkg::FLAGS_RST;
        end else begin
            if (cmd_go) begin
                case (cmd_op)
                    csfu_pkg::CSFU_OP_CLRWDT: begin
                        flags[csfu_pkg::FLG_TO] <= 1'b0;
                        flags[csfu_pkg::FLG_PDF] <= 1'b0;
                    end
                    csfu_pkg::CSFU_OP_HALT: begin
                        flags[csfu_pkg::FLG_TO] <= 1'b0;
                        flags[csfu_pkg::FLG_PDF] <= 1'b1;
                    end
                    csfu_pkg::CSFU_OP_NOP, csfu_pkg::CSFU_OP_TABRD,
                    csfu_pkg::CSFU_OP_MOV: begin
                    end
                    csfu_pkg::CSFU_OP_RLC, csfu_pkg::CSFU_OP_RRC: begin
                        flags[csfu_pkg::FLG_C] <= alu_bus.c;
                    end
                    default: begin
                        // Same cycle as the result write
                        flags[csfu_pkg::FLG_Z] <= alu_bus.z;
                        if (alu_bus.is_arith) begin
                            flags[csfu_pkg::FLG_C] <= alu_bus.c;
                            flags[csfu_pkg::FLG_AC] <= alu_bus.ac;
                            flags[csfu_pkg::FLG_OV] <= alu_bus.ov;
                            flags[csfu_pkg::FLG_SC] <= alu_bus.sc;
                        end
                        if (cmd_op == csfu_pkg::CSFU_OP_SUB ||
                                cmd_op == csfu_pkg::CSFU_OP_SUBTRACT_TO_MEMORY_INSTRUCTION) begin
                            flags[csfu_pkg::FLG_CZ] <= alu_bus.z;
                        end else if (cmd_op == csfu_pkg::CSFU_OP_SBC ||
                                cmd_op == csfu_pkg::CSFU_OP_SBCM) begin
                            flags[csfu_pkg::FLG_CZ] <=
                                flags[csfu_pkg::FLG_CZ] & alu_bus.z;
                        end
                    end
                endcase
            end else if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_FLAGS)) begin
                flags <= (wd & csfu_pkg::FLAGS_WMASK) |
                    (flags & ~csfu_pkg::FLAGS_WMASK);
            end
            // Time-out wins over a simultaneous clear
            if (wdt_ev) begin
                flags[csfu_pkg::FLG_TO] <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------
    // Program counter and table read
    // --------------------------------------------------------
    logic [$clog2(csfu_pkg::DUMMY_CYC+1)-1:0] dummy_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc <= '0;
            dummy_cnt <= '0;
        end else if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_PCLB)) begin
            // Only the low byte moves, so the jump stays in the page
            pc[7:0] <= wd;
            dummy_cnt <= ($bits(dummy_cnt))'(csfu_pkg::DUMMY_CYC);
        end else if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_PCFULL)) begin
            pc <= hwdata[PC_W-1:0];
        end else if (dummy_cnt != '0) begin
            dummy_cnt <= dummy_cnt - 1'b1;
        end
    end
    assign dummy_cycle = (dummy_cnt != '0);

    logic [15:0] tbl_ptr;
    assign tbl_ptr = {tph, tpl};
    assign tbl_addr = tbl_ptr[PC_W-1:0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tpl <= 8'h00;
            tph <= 8'h00;
            thr <= 8'h00;
            tbl_low <= 8'h00;
        end else begin
            if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_TPL)) begin
                tpl <= wd;
            end
            if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_TPH)) begin
                tph <= wd;
            end
            if (cmd_go && cmd_op == csfu_pkg::CSFU_OP_TABRD) begin
                thr <= tbl_word[15:8];
                tbl_low <= tbl_word[7:0];
            end else if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_THR)) begin
                thr <= wd;
            end
        end
    end

    // --------------------------------------------------------
    // Extended direct address
    // --------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_addr <= 16'h0000;
        end else if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_EXTADDR)) begin
            ext_addr <= hwdata[15:0];
        end
    end
    assign sector = ext_addr[8 +: SECT_W];
    assign sector_offset = ext_addr[7:0];

    // --------------------------------------------------------
    // Interrupts
    // --------------------------------------------------------
    logic [IRQ_W_L-1:0] irq_set;
    always_comb begin
        irq_set = '0;
        irq_set[csfu_pkg::IRQ_TIMEOUT] = wdt_ev;
        irq_set[csfu_pkg::IRQ_JUMP] = wr_go &&
            is_idx(ap_addr, csfu_pkg::IDX_PCLB);
        irq_set[csfu_pkg::IRQ_TABLE] = cmd_go &&
            cmd_op == csfu_pkg::CSFU_OP_TABRD;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            // Set beats a same-cycle write-one clear
            if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_IRQSTAT)) begin
                irq_stat <= (irq_stat & ~hwdata[IRQ_W_L-1:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
            if (wr_go && is_idx(ap_addr, csfu_pkg::IDX_IRQMASK)) begin
                irq_mask <= hwdata[IRQ_W_L-1:0];
            end
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // --------------------------------------------------------
    // Read mux
    // --------------------------------------------------------
    always_comb begin
        hrdata = 32'h00000000;
        if (rd_pend) begin
            // Indirect locations and unmapped words fall through to zero
            case (ap_addr[9:2])
                csfu_pkg::IDX_ACC: hrdata[7:0] = acc;
                csfu_pkg::IDX_PCLB: hrdata[7:0] = pc[7:0];
                csfu_pkg::IDX_TPL: hrdata[7:0] = tpl;
                csfu_pkg::IDX_TPH: hrdata[7:0] = tph;
                csfu_pkg::IDX_THR: hrdata[7:0] = thr;
                csfu_pkg::IDX_FLAGS: hrdata[7:0] = flags;
                csfu_pkg::IDX_OPND: hrdata[7:0] = opnd;
                csfu_pkg::IDX_RESULT: hrdata[7:0] = result;
                csfu_pkg::IDX_EXTADDR: hrdata[15:0] = ext_addr;
                csfu_pkg::IDX_PCFULL: hrdata[PC_W-1:0] = pc;
                csfu_pkg::IDX_TBLDATA: hrdata[7:0] = tbl_low;
                csfu_pkg::IDX_IRQSTAT: hrdata[IRQ_W_L-1:0] = irq_stat;
                csfu_pkg::IDX_IRQMASK: hrdata[IRQ_W_L-1:0] = irq_mask;
                csfu_pkg::IDX_SECTOR: hrdata[SECT_W-1:0] = sector;
                csfu_pkg::IDX_OFFSET: hrdata[7:0] = sector_offset;
                default: hrdata = 32'h00000000;
            endcase
            if (ap_addr[31:10] != 22'h000000) begin
                hrdata = 32'h00000000;
            end
        end
    end
endmodule // csfu_core

// ==== csfu_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Flag unit checker
// ----------------------------------------
module csfu_monitor #(
    parameter int PC_W = 13,
    parameter int SECT_W = 2
) (
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Core side
    input wire logic wdt_timeout,
    input wire logic [PC_W-1:0] tbl_addr,
    input wire logic [PC_W-1:0] pc,
    input wire logic dummy_cycle,
    input wire logic [SECT_W-1:0] sector,
    input wire logic [7:0] sector_offset
);
    logic dp_w, dp_r, clean;
    logic [7:0] dp_i;
    logic [3:0] quiet;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_w <= 1'b0;
            dp_r <= 1'b0;
            dp_i <= 8'h00;
        end else if (hready) begin
            dp_w <= hsel & htrans[1] & hwrite;
            dp_r <= hsel & htrans[1] & !hwrite;
            dp_i <= haddr[9:2];
        end
    end

    // Quiet count: a pin event lands some cycles after the pin rises
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet <= 4'h0;
            clean <= 1'b1;
        end else begin
            quiet <= wdt_timeout ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
            if (wdt_timeout || (dp_w && dp_i == csfu_pkg::IDX_CMD)) begin
                clean <= 1'b0;
            end
        end
    end

    wire pcl_w = dp_w && dp_i == csfu_pkg::IDX_PCLB;
    wire ext_w = dp_w && dp_i == csfu_pkg::IDX_EXTADDR;
    wire flg_w = dp_w && dp_i == csfu_pkg::IDX_FLAGS;
    wire flg_r = dp_r && dp_i == csfu_pkg::IDX_FLAGS;
    wire tpl_w = dp_w && dp_i == csfu_pkg::IDX_TPL;
    wire tph_w = dp_w && dp_i == csfu_pkg::IDX_TPH;
    wire ind_r = dp_r && (dp_i inside {csfu_pkg::IDX_IND0,
        csfu_pkg::IDX_IND1, csfu_pkg::IDX_IND2});

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    pcl_dummy_a: assert property (pcl_w |=> dummy_cycle ##1
        (!dummy_cycle || $past(pcl_w))) else $error("no single dummy");
    pc_page_a: assert property (pcl_w |=>
        pc[7:0] == $past(hwdata[7:0]) && pc[PC_W-1:8] == $past(pc[PC_W-1:8]))
        else $error("bad jump");
    ext_split_a: assert property (ext_w |=>
        sector == $past(hwdata[8+:SECT_W]) && sector_offset ==
        $past(hwdata[7:0])) else $error("bad sector split");
    tbl_low_a: assert property (tpl_w |=>
        tbl_addr[7:0] == $past(hwdata[7:0])) else $error("bad table low");
    tbl_high_a: assert property (tph_w |=>
        tbl_addr[PC_W-1:8] == $past(hwdata[PC_W-9:0]))
        else $error("bad table high");
    ind_zero_a: assert property (ind_r |-> hrdata == 32'h0)
        else $error("indirect not zero");
    flag_ro_a: assert property (
        flg_r ##2 flg_w ##2 (flg_r && quiet == 4'hF)
        |-> hrdata[5:4] == $past(hrdata[5:4], 4))
        else $error("ro bits moved");
    pwr_on_a: assert property (
        flg_r && clean |-> hrdata[5:4] == 2'h0)
        else $error("power-on bits set");

    cover property (pcl_w);
    cover property (ext_w);
    cover property (flg_r ##2 flg_w ##2 flg_r);
    cover property (ind_r);
endmodule // csfu_monitor

bind csfu_core csfu_monitor #(.PC_W(PC_W), .SECT_W(SECT_W)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .wdt_timeout(wdt_timeout), .tbl_addr(tbl_addr),
    .pc(pc), .dummy_cycle(dummy_cycle), .sector(sector),
    .sector_offset(sector_offset));

// ==== csfu_pkg.sv ====
package csfu_pkg;
    // Register word indexes (index = data memory location, byte addr = 4x)
    localparam logic [7:0] IDX_IND0 = 8'h00;
    localparam logic [7:0] IDX_ACC = 8'h05;
    localparam logic [7:0] IDX_PCLB = 8'h06;
    localparam logic [7:0] IDX_TPL = 8'h07;
    localparam logic [7:0] IDX_THR = 8'h08;
    localparam logic [7:0] IDX_TPH = 8'h09;
    localparam logic [7:0] IDX_FLAGS = 8'h0A;
    localparam logic [7:0] IDX_IND1 = 8'h02;
    localparam logic [7:0] IDX_IND2 = 8'h0C;
    // Own control and status block
    localparam logic [7:0] IDX_CMD = 8'h20;
    localparam logic [7:0] IDX_OPND = 8'h21;
    localparam logic [7:0] IDX_RESULT = 8'h22;
    localparam logic [7:0] IDX_EXTADDR = 8'h23;
    localparam logic [7:0] IDX_PCFULL = 8'h24;
    localparam logic [7:0] IDX_TBLDATA = 8'h25;
    localparam logic [7:0] IDX_IRQSTAT = 8'h26;
    localparam logic [7:0] IDX_IRQMASK = 8'h27;
    localparam logic [7:0] IDX_SECTOR = 8'h28;
    localparam logic [7:0] IDX_OFFSET = 8'h29;
    // Flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_PDF = 4;
    localparam int FLG_TO = 5;
    localparam int FLG_CZ = 6;
    localparam int FLG_SC = 7;
    // Software may write every bit but watchdog and power-down
    localparam logic [7:0] FLAGS_WMASK = 8'hCF;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // Interrupt status bits
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_JUMP = 1;
    localparam int IRQ_TABLE = 2;
    localparam int IRQ_W = 3;
    // Jump dummy-cycle count
    localparam int DUMMY_CYC = 1;

    typedef enum logic [3:0] {
        CSFU_OP_NOP, CSFU_OP_ADD, CSFU_OP_ADC, CSFU_OP_SUB, CSFU_OP_SUBTRACT_TO_MEMORY_INSTRUCTION,
        CSFU_OP_SBC, CSFU_OP_SBCM, CSFU_OP_AND, CSFU_OP_OR, CSFU_OP_XOR,
        CSFU_OP_RLC, CSFU_OP_RRC, CSFU_OP_CLRWDT, CSFU_OP_HALT,
        CSFU_OP_TABRD, CSFU_OP_MOV
    } csfu_op_e;
endpackage
